// file: core/ism_slot_mapper.v
// indicator slot mapper: apb registers, slot schedule and serial bit output
//
// What this block does
// - split mode maps two 15-bit code words
// - low spreading factor sends each bit four times
// - split repetition: word1 bit four, word2 four
// - compressed placement follows puncture or halving method
// - two bits unsplit: sequence equals code word
// - eight bits unsplit: repetitions per bit, 119
// - split two bits: word2, word1 alternate
// - split eight bits: repeats word2 then word1
// - puncturing keeps all bits; Z is (C+1)/15
// - gap3: slots 3+2x carry 1.5Z bits
// - gap3: slots 4+2x carry Z bits
// - gap4: slot 4 carries no bits
// - gap4: slots 5+x carry 1.5Z bits
// - uplink halving repeats bits to fill capacity
// - E is 29 minus first*width mod 30
// - repeats continue downward from index E mod 30
// - send originals descending, then the repeats
// - within a slot higher bit goes first
//
// Local design decisions: register access over APB and the placing of the registers.
`include "ism_regs.vh"

module ism_slot_mapper (
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`ISM_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output wire                   pready,
  output reg                    pslverr,
  output wire                   map_valid,
  input  wire                   map_ready,
  output reg                    map_bit,
  output reg  [3:0]             map_slot,
  output reg                    map_frame_end
);

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_LOAD = 2'b01;
  localparam [1:0] ST_EMIT = 2'b10;

  reg [1:0]            state_q;
  reg [1:0]            state_d;
  reg [19:0]           ctrl_q;
  reg [`ISM_CW_W-1:0]  cword_q;
  reg                  done_q;
  reg [3:0]            slot_q;
  reg [3:0]            cnt_q;
  reg [6:0]            idx_q;
  reg                  wrap_q;
  reg [6:0]            sent_q;
  reg [3:0]            slot_d;
  reg [3:0]            cnt_d;
  reg [6:0]            idx_d;
  reg                  wrap_d;
  reg [6:0]            sent_d;
  wire                 c_bit;

  wire split   = ctrl_q[`ISM_CTRL_SPLIT];
  wire rep8    = ctrl_q[`ISM_CTRL_REP8];
  wire comp    = ctrl_q[`ISM_CTRL_COMP];
  wire sfr     = ctrl_q[`ISM_CTRL_SFR];
  wire gap4    = ctrl_q[`ISM_CTRL_GAP4];
  wire [3:0] first_gap = ctrl_q[`ISM_CTRL_FIRST];
  wire [3:0] last_gap  = ctrl_q[`ISM_CTRL_LAST];
  wire [3:0] nfld      = ctrl_q[`ISM_CTRL_NFLD];

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // bits that a slot carries for the current settings
  function [3:0] slot_bits;
    input [3:0] s;
    input       f_comp;
    input       f_sfr;
    input       f_gap4;
    input       f_rep8;
    input [3:0] f_first;
    input [3:0] f_last;
    input [3:0] f_n;
    reg   [3:0] z;
    reg   [3:0] zh;
    begin
      z  = f_rep8 ? `ISM_Z_8BIT : `ISM_Z_2BIT;
      zh = f_rep8 ? `ISM_ZH_8BIT : `ISM_ZH_2BIT;
      if (!f_comp)
        slot_bits = z;
      else if (f_sfr) begin
        if (s >= f_first && s <= f_last)
          slot_bits = 4'h0;
        else
          slot_bits = f_n;
      end else if (f_gap4) begin
        if (s <= `ISM_GAP4_EMPTY)
          slot_bits = 4'h0;
        else
          slot_bits = zh;
      end else begin
        if (s < `ISM_GAP3_FIRST)
          slot_bits = 4'h0;
        else if (s[0])
          slot_bits = zh;
        else
          slot_bits = z;
      end
    end
  endfunction

  // reduces a small product modulo thirty
  function [4:0] mod30;
    input [7:0] v;
    reg   [7:0] r;
    begin
      r     = v % `ISM_MOD;
      mod30 = r[4:0];
    end
  endfunction

  // first sequence index of a frame: the top of c for the bit density
  function [6:0] start_idx;
    input f_rep8;
    begin
      start_idx = f_rep8 ? `ISM_C_8BIT : `ISM_C_2BIT;
    end
  endfunction

  wire [7:0] first_prod = first_gap * nfld;
  wire [4:0] e_idx      = 5'd29 - mod30(first_prod);
  wire [3:0] cur_bits   = slot_bits(slot_q, comp, sfr, gap4, rep8,
                                    first_gap, last_gap, nfld);
  wire       slot_full  = (cnt_q == cur_bits);
  wire       last_slot  = (slot_q == `ISM_LAST_SLOT);
  // repeats only exist under uplink halving, at either bit density
  wire       rep_mode   = comp & sfr;

  // ---------------------------------------------------------------
  // sequence bit lookup
  // ---------------------------------------------------------------
  ism_seq_pick u_pick (
    .cword (cword_q),
    .split (split),
    .rep8  (rep8),
    .idx   (idx_q),
    .c_bit (c_bit)
  );

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;

  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire busy     = (state_q != ST_IDLE);
  wire hit_ctrl = (paddr == `ISM_ADR_CTRL);
  wire hit_cw   = (paddr == `ISM_ADR_CWORD);
  wire hit_st   = (paddr == `ISM_ADR_STATUS);
  wire start    = wr & hit_ctrl & ~busy & pwdata[`ISM_CTRL_START];

  always @* begin
    prdata  = 32'h00000000;
    pslverr = 1'b0;
    if (acc) begin
      if (hit_ctrl)
        prdata = {12'h000, ctrl_q[19:1], 1'b0};
      else if (hit_cw)
        prdata = {2'b00, cword_q};
      else if (hit_st)
        prdata = {17'h00000, sent_q, slot_q, 2'b00, done_q, busy};
      else
        pslverr = 1'b1;
    end
  end

  // settings are frozen while a frame is mapped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `ISM_CTRL_RST;
      cword_q <= `ISM_CW_RST;
    end else if (wr & ~busy) begin
      if (hit_ctrl)
        ctrl_q <= {pwdata[19:1], 1'b0};
      if (hit_cw)
        cword_q <= pwdata[`ISM_CW_W-1:0];
    end
  end

  // done: set by frame end, cleared by writing one; set wins
  wire frame_done = (state_q == ST_LOAD) & slot_full & last_slot;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      done_q <= 1'b0;
    else if (frame_done)
      done_q <= 1'b1;
    else if (wr & hit_st & pwdata[`ISM_ST_DONE])
      done_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // slot schedule
  // ---------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start)
          state_d = ST_LOAD;
      end
      ST_LOAD: begin
        if (!slot_full)
          state_d = ST_EMIT;
        else if (last_slot)
          state_d = ST_IDLE;
      end
      ST_EMIT: begin
        if (map_ready)
          state_d = ST_LOAD;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  assign map_valid = (state_q == ST_EMIT);

  // ---------------------------------------------------------------
  // next schedule values
  // ---------------------------------------------------------------
  // the start index comes from the start write itself: ctrl_q only takes
  // the new settings at that same edge, so it still holds the old density
  always @* begin
    slot_d = slot_q;
    cnt_d  = cnt_q;
    idx_d  = idx_q;
    wrap_d = wrap_q;
    sent_d = sent_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          slot_d = 4'h0;
          cnt_d  = 4'h0;
          idx_d  = start_idx(pwdata[`ISM_CTRL_REP8]);
          wrap_d = 1'b0;
          sent_d = 7'h00;
        end
      end
      ST_LOAD: begin
        if (slot_full & ~last_slot) begin
          slot_d = slot_q + 4'h1;
          cnt_d  = 4'h0;
        end
      end
      ST_EMIT: begin
        if (map_ready) begin
          cnt_d  = cnt_q + 4'h1;
          sent_d = sent_q + 7'h01;
          if (rep_mode & ~wrap_q & (idx_q == 7'h00)) begin
            idx_d  = {2'b00, e_idx};
            wrap_d = 1'b1;
          end else if (wrap_q & (idx_q == 7'h00))
            idx_d = `ISM_C_2BIT;
          else if (idx_q != 7'h00)
            idx_d = idx_q - 7'h01;
          // outside halving a sequence is never exhausted before its slots are: the
          // slot counts above add up to C+1 in every puncture case
        end
      end
      default: ;
    endcase
  end

  // ---------------------------------------------------------------
  // schedule and output registers
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q       <= ST_IDLE;
      slot_q        <= 4'h0;
      cnt_q         <= 4'h0;
      idx_q         <= 7'h00;
      wrap_q        <= 1'b0;
      sent_q        <= 7'h00;
      map_bit       <= 1'b0;
      map_slot      <= 4'h0;
      map_frame_end <= 1'b0;
    end else begin
      state_q <= state_d;
      slot_q  <= slot_d;
      cnt_q   <= cnt_d;
      idx_q   <= idx_d;
      wrap_q  <= wrap_d;
      sent_q  <= sent_d;
      if ((state_q == ST_LOAD) & ~slot_full) begin
        // indices count down in every mode; under halving the repeats restart at E after index 0
        map_bit       <= c_bit;
        map_slot      <= slot_q;
        map_frame_end <= last_slot & (cnt_q + 4'h1 == cur_bits);
      end
    end
  end

endmodule // ism_slot_mapper

// file: core/ism_regs.vh
// register map, field positions and mapping constants of the indicator slot mapper
`ifndef ISM_REGS_VH
`define ISM_REGS_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define ISM_ADDR_W      12
`define ISM_ADR_CTRL    12'h000
`define ISM_ADR_CWORD   12'h004
`define ISM_ADR_STATUS  12'h008

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define ISM_CTRL_START  0
`define ISM_CTRL_SPLIT  1
`define ISM_CTRL_REP8   2
`define ISM_CTRL_COMP   3
`define ISM_CTRL_SFR    4
`define ISM_CTRL_GAP4   5
`define ISM_CTRL_FIRST  11:8
`define ISM_CTRL_LAST   15:12
`define ISM_CTRL_NFLD   19:16
`define ISM_CTRL_RST    20'h00000

// ---------------------------------------------------------------
// code word register fields
// ---------------------------------------------------------------
`define ISM_CW_W        30
`define ISM_CW1         29:15
`define ISM_CW2         14:0
`define ISM_CW_RST      30'h00000000

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define ISM_ST_BUSY     0
`define ISM_ST_DONE     1
`define ISM_ST_SLOT     7:4
`define ISM_ST_COUNT    14:8

// ---------------------------------------------------------------
// frame and sequence constants
// ---------------------------------------------------------------
`define ISM_LAST_SLOT   4'he
`define ISM_C_2BIT      7'h1d
`define ISM_C_8BIT      7'h77
`define ISM_Z_2BIT      4'h2
`define ISM_Z_8BIT      4'h8
`define ISM_ZH_2BIT     4'h3
`define ISM_ZH_8BIT     4'hc
`define ISM_MOD         8'h1e
`define ISM_GAP3_FIRST  4'h3
`define ISM_GAP4_EMPTY  4'h4

`endif

// file: core/ism_seq_pick.v
// picks one bit of the serial indicator sequence c from the code words
`include "ism_regs.vh"

module ism_seq_pick (
  input  wire [`ISM_CW_W-1:0] cword,
  input  wire                 split,
  input  wire                 rep8,
  input  wire [6:0]           idx,
  output reg                  c_bit
);

  reg [6:0] unit_idx;
  reg [3:0] pos;

  // ---------------------------------------------------------------
  // sequence selection
  // ---------------------------------------------------------------
  // four repeats of one bit share a value, so index/4 names the code bit
  always @* begin
    unit_idx = rep8 ? {2'b00, idx[6:2]} : idx;
    pos      = unit_idx[4:1];
    if (split) begin
      if (unit_idx[0])
        c_bit = cword[15 + pos];
      else
        c_bit = cword[pos];
    end else begin
      if (unit_idx[4:0] < 5'd30)
        c_bit = cword[unit_idx[4:0]];
      else
        c_bit = 1'b0;
    end
  end

endmodule // ism_seq_pick

// file: bench/ism_slot_mapper_properties.sv
// port checker for the indicator slot mapper
module ism_slot_mapper_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        map_valid,
  input logic        map_ready,
  input logic        map_bit,
  input logic [3:0]  map_slot,
  input logic        map_frame_end
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] last_slot_q;
  logic       acc;
  logic       take;
  assign acc  = psel && penable;
  assign take = map_valid && map_ready;
  // ----------------------------------------
  // slot floor
  // ----------------------------------------
  // cleared on start too, since a frame whose slot 14 is empty never raises map_frame_end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) last_slot_q <= 4'h0;
    else if (acc && pwrite && paddr == 12'h000 && pwdata[0]) last_slot_q <= 4'h0;
    else if (take) last_slot_q <= map_frame_end ? 4'h0 : map_slot;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_hold;
    map_valid && !map_ready |=> map_valid && $stable(map_bit) && $stable(map_slot);
  endproperty
  a_hold: assert property (p_hold)
    else $error("offered bit moved while stalled");
  property p_load;
    take |=> !map_valid;
  endproperty
  a_load: assert property (p_load)
    else $error("no load cycle after a take");
  property p_mono;
    map_valid |-> map_slot >= last_slot_q;
  endproperty
  a_mono: assert property (p_mono)
    else $error("slot went backwards");
  property p_max;
    map_valid |-> map_slot <= 4'he;
  endproperty
  a_max: assert property (p_max)
    else $error("slot beyond 14");
  property p_end;
    map_frame_end && map_valid |-> map_slot == 4'he;
  endproperty
  a_end: assert property (p_end)
    else $error("frame end off slot 14");
  property p_quiet;
    take && map_frame_end |=> !map_valid [*3];
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("bits after frame end");
  property p_err;
    acc && paddr > 12'h008 |-> pslverr && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err)
    else $error("unmapped access not refused");
  property p_ok;
    acc && paddr <= 12'h008 && paddr[1:0] == 2'h0 |-> !pslverr && pready;
  endproperty
  a_ok: assert property (p_ok)
    else $error("mapped access refused");
  property p_idle;
    !acc |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read bus busy outside access");
  c_stall: cover property (map_valid && !map_ready);
  c_end: cover property (take && map_frame_end);
  c_err: cover property (acc && pslverr);
endmodule // ism_slot_mapper_props

bind ism_slot_mapper ism_slot_mapper_props u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .map_valid, .map_ready,
  .map_bit, .map_slot, .map_frame_end);

// file: bench/ism_sink.sv
// slot builder model: takes offered bits, promptly or slowly
module ism_sink (
  input  logic       pclk,
  input  logic       presetn,
  input  logic       slow,
  input  logic       map_valid,
  input  logic       map_bit,
  input  logic [3:0] map_slot,
  input  logic       map_frame_end,
  output logic       map_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_q;
  logic       qb[$];
  logic [3:0] qs[$];
  logic       qf[$];
  // slow mode takes one bit in four cycles to stretch every hold
  assign map_ready = !slow || cnt_q == 2'h3;
  always @(posedge pclk or negedge presetn)
    if (!presetn) cnt_q <= 2'h0;
    else begin
      cnt_q <= cnt_q + 2'h1;
      if (map_valid && map_ready) begin
        qb.push_back(map_bit);
        qs.push_back(map_slot);
        qf.push_back(map_frame_end);
      end
    end
endmodule // ism_sink

// file: bench/ism_slot_mapper_tb.sv
// self-checking bench for the indicator slot mapper
module ism_slot_mapper_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se, slow;
  logic        map_valid, map_ready, map_bit, map_frame_end;
  logic [3:0]  map_slot;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        eb[128];
  logic [3:0]  es[128];
  int          errors, n_compared, ne, base;
  // control word with start set, beside the code word
  logic [49:0] rows[10] = '{{20'h00001, 30'h1b5c3e19}, {20'h00005, 30'h0a3f5c6d},
    {20'h00003, 30'h1b5c3e19}, {20'h00007, 30'h2e4d1b97}, {20'h00009, 30'h0a3f5c6d},
    {20'h0000d, 30'h1b5c3e19}, {20'h00029, 30'h2e4d1b97}, {20'h0002f, 30'h0a3f5c6d},
    {20'h37519, 30'h1b5c3e19}, {20'h3ec19, 30'h2e4d1b97}};
  ism_sink sink (.pclk, .presetn, .slow, .map_valid, .map_bit, .map_slot, .map_frame_end,
    .map_ready);
  ism_slot_mapper dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .map_valid, .map_ready, .map_bit, .map_slot,
    .map_frame_end);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_done;
    rd = 32'h0;
    while (rd[1] !== 1'b1) apb(1'b0, 12'h008, 32'h0);
  endtask
  function automatic logic cbit(logic [19:0] c, logic [29:0] w, int k);
    int m;
    m = c[2] ? k / 4 : k;
    return c[1] ? (m % 2 ? w[15 + m / 2] : w[m / 2]) : w[m];
  endfunction
  // expected order: c descending, then the repeats walking down from e
  task automatic build(input logic [19:0] c, input logic [29:0] w);
    int cc, z, e, per;
    cc = c[2] ? 119 : 29;
    z = c[2] ? 8 : 2;
    e = 29 - (c[11:8] * c[19:16]) % 30;
    ne = 0;
    for (int s = 0; s < 15; s++) begin
      if (!c[3]) per = z;
      else if (c[4]) per = (s >= c[11:8] && s <= c[15:12]) ? 0 : c[19:16];
      else if (c[5]) per = s < 5 ? 0 : 3 * z / 2;
      else per = s < 3 ? 0 : (s % 2 ? 3 * z / 2 : z);
      repeat (per) begin
        eb[ne] = cbit(c, w, ne <= cc ? cc - ne : (e - (ne - 30) + 30) % 30);
        es[ne] = s[3:0];
        ne++;
      end
    end
  endtask
  task automatic run(input logic [49:0] r);
    base = sink.qb.size();
    build(r[49:30], r[29:0]);
    apb(1'b1, 12'h004, {2'h0, r[29:0]});
    apb(1'b1, 12'h000, {12'h0, r[49:30]});
    wait_done();
    chk(rd[14:8], ne[6:0]);
    chk(rd[7:4], 32'he);
    chk(rd[0], 32'h0);
    apb(1'b1, 12'h008, 32'h2);
    chk(sink.qb.size() - base, ne);
    for (int i = 0; i < ne; i++) begin
      chk(sink.qb[base + i], eb[i]);
      chk(sink.qs[base + i], es[i]);
      chk(sink.qf[base + i], i == ne - 1 && es[i] == 4'he);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    #3000000;
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    {psel, penable, pwrite, slow, presetn} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 12; a += 4) begin
      apb(1'b0, a[11:0], 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h00c, 32'h0);
    chk(se, 32'h1);
    $display("test reset and map done");
    foreach (rows[i]) begin
      slow <= i[0];
      run(rows[i]);
      $display("test %0d done", i);
    end
    // writes while busy are dropped, and start never reads back
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h004, 32'h0);
    wait_done();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, {2'h0, rows[9][29:0]});
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h008, 32'h2);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[1], 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    repeat (10) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    chk(map_valid, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    $display("test busy and reset done");
    finish_test();
  end
endmodule // ism_slot_mapper_tb
